// ===== core/asci_pkg.sv
package asci_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ADR_CTRL       = 8'h00;
  localparam logic [7:0] ADR_SETPOINT1  = 8'h04;
  localparam logic [7:0] ADR_SETPOINT2  = 8'h08;
  localparam logic [7:0] ADR_STATUS     = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK   = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_ZERO_BIT  = 0;
  localparam int unsigned CTRL_SPAN_BIT  = 1;
  localparam int unsigned CTRL_RANGE_LSB = 2;
  localparam int unsigned CTRL_W         = 4;

  // Interrupt status and mask fields, same layout in both registers
  localparam int unsigned IRQ_FAULT       = 0;
  localparam int unsigned IRQ_FIRST_THRESHOLD_ALARM      = 1;
  localparam int unsigned IRQ_SECOND_THRESHOLD_ALARM      = 2;
  localparam int unsigned IRQ_REMOTE_ZERO = 3;
  localparam int unsigned IRQ_REMOTE_SPAN = 4;
  localparam int unsigned IRQ_W           = 5;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST     = 4'h0;
  localparam logic [31:0]       SETPOINT_RST = 32'hFFFFFFFF;
  localparam logic [IRQ_W-1:0]  IRQ_RST      = 5'h00;

  // Stages of the input synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // Range configuration held in the control register
  typedef enum logic [1:0] {
    RANGE_SINGLE = 2'h0,
    RANGE_DUAL   = 2'h1,
    RANGE_AUTO   = 2'h2
  } asci_range_type;

  // Calibration sequencer, Gray codes along idle-zero-span
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_ZERO = 2'h1,
    CAL_SPAN = 2'h3
  } asci_cal_type;

  // The eight status outputs, output 1 in bit 0
  typedef struct packed {
    logic second_threshold_alarm;
    logic first_threshold_alarm;
    logic diagnostic_active;
    logic span_cal;
    logic zero_cal;
    logic high_range;
    logic reading_valid_flag;
    logic system_ok;
  } asci_status_type;

  // Mode indication towards the display
  typedef struct packed {
    logic cal_remote;
    logic cal_span;
    logic cal_zero;
  } asci_mode_type;

endpackage : asci_pkg

// ===== core/asci_status_io.sv
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps

// Notes on behaviour
// - System-ok output high when no fault is present, low while any fault exists.
// - Reading-valid output follows validity of the current concentration reading.
// - High-range output only in upper range with dual or automatic range mode.
// - Zero-calibration output stays high for the whole zero calibration.
// - Span-calibration output stays high for the whole span calibration.
// - Diagnostic output high exactly while the diagnostic mode is active.
// - Each alarm output high while concentration exceeds its own setpoint.
// - Remote zero input enters zero calibration, flagged as remotely started.
// - Remote span input enters span calibration unless a zero request stands, flagged as remotely started.
module asci_status_io #(
  parameter int unsigned CONC_W  = 16,
  parameter int unsigned FAULT_W = 8
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          irq_o,
  input  wire logic [FAULT_W-1:0]       fault_flags,
  input  wire logic                     reading_ok,
  input  wire logic                     upper_range,
  input  wire logic                     diagnostic_active_in,
  input  wire logic [CONC_W-1:0]        concentration,
  input  wire logic                     remote_zero_in,
  input  wire logic                     remote_span_in,
  input  wire logic [3:0]               spare_in,
  output asci_pkg::asci_status_type     status_out,
  output asci_pkg::asci_mode_type       mode_out
);

  logic [CONC_W-1:0]               setpoint_reg [2];
  logic [asci_pkg::CTRL_W-1:0]     ctrl_reg;
  logic [asci_pkg::IRQ_W-1:0]      irq_status_reg;
  logic [asci_pkg::IRQ_W-1:0]      irq_status_next;
  logic [asci_pkg::IRQ_W-1:0]      irq_mask_reg;
  logic [asci_pkg::IRQ_W-1:0]      irq_set;
  logic [asci_pkg::SYNC_STAGES-1:0] zero_sync_reg;
  logic [asci_pkg::SYNC_STAGES-1:0] span_sync_reg;
  logic                            zero_sync;
  logic                            span_sync;
  logic                            zero_sync_prev_reg;
  logic                            span_sync_prev_reg;
  asci_pkg::asci_cal_type          cal_state_reg;
  asci_pkg::asci_cal_type          cal_state_next;
  asci_pkg::asci_range_type        range_mode;
  asci_pkg::asci_status_type       status_reg;
  asci_pkg::asci_status_type       status_next;
  asci_pkg::asci_mode_type         mode_reg;
  asci_pkg::asci_mode_type         mode_next;
  logic [1:0]                      alarm_hit;
  logic                            zero_req;
  logic                            span_req;
  logic                            bus_req;
  logic                            bus_done;
  logic                            ack_reg;
  logic [31:0]                     rdata_reg;
  logic [31:0]                     rdata_next;
  wire logic [31:0]                wr_word;

  // Spare inputs feed nothing; only the two calibration requests are sampled
  assign zero_sync = zero_sync_reg[asci_pkg::SYNC_STAGES-1];
  assign span_sync = span_sync_reg[asci_pkg::SYNC_STAGES-1];

  // Two flops per request line, first stage read only by the second
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      zero_sync_reg <= '0;
      span_sync_reg <= '0;
    end
    else
    begin
      zero_sync_reg <= {zero_sync_reg[0], remote_zero_in};
      span_sync_reg <= {span_sync_reg[0], remote_span_in};
    end
  end

  // Edge memory for the remote request events
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      zero_sync_prev_reg <= 1'b0;
      span_sync_prev_reg <= 1'b0;
    end
    else
    begin
      zero_sync_prev_reg <= zero_sync;
      span_sync_prev_reg <= span_sync;
    end
  end

  // Remote and local requests are ORed together; zero takes priority over span
  assign zero_req = zero_sync | ctrl_reg[asci_pkg::CTRL_ZERO_BIT];
  assign span_req = span_sync | ctrl_reg[asci_pkg::CTRL_SPAN_BIT];

  // Calibration sequencer; a phase lasts as long as its request stands, a zero request cutting span short
  always_comb
  begin
    cal_state_next = cal_state_reg;
    unique case (cal_state_reg)
      asci_pkg::CAL_IDLE:
      begin
        if (zero_req)
          cal_state_next = asci_pkg::CAL_ZERO;
        else if (span_req)
          cal_state_next = asci_pkg::CAL_SPAN;
      end
      asci_pkg::CAL_ZERO:
      begin
        if (!zero_req)
          cal_state_next = asci_pkg::CAL_IDLE;
      end
      asci_pkg::CAL_SPAN:
      begin
        if (zero_req)
          cal_state_next = asci_pkg::CAL_ZERO;
        else if (!span_req)
          cal_state_next = asci_pkg::CAL_IDLE;
      end
      default:
        cal_state_next = asci_pkg::CAL_IDLE;
    endcase
  end

  // Mode indication marks a phase as remote while its remote input holds it
  always_comb
  begin
    mode_next.cal_zero   = (cal_state_next == asci_pkg::CAL_ZERO);
    mode_next.cal_span   = (cal_state_next == asci_pkg::CAL_SPAN);
    mode_next.cal_remote = (mode_next.cal_zero & zero_sync) |
                           (mode_next.cal_span & span_sync);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cal_state_reg <= asci_pkg::CAL_IDLE;
      mode_reg      <= '0;
    end
    else
    begin
      cal_state_reg <= cal_state_next;
      mode_reg      <= mode_next;
    end
  end

  // Illegal code 3 behaves as single range so high range stays off
  assign range_mode = asci_pkg::asci_range_type'(ctrl_reg[asci_pkg::CTRL_RANGE_LSB +: 2]);

  // Alarm comparators, one per setpoint
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_alarm
      assign alarm_hit[g] = (concentration > setpoint_reg[g]);
    end
  endgenerate

  // Next value of the eight status outputs
  always_comb
  begin
    status_next.system_ok              = ~(|fault_flags);
    status_next.reading_valid_flag     = reading_ok;
    status_next.high_range             = upper_range &
                                         ((range_mode == asci_pkg::RANGE_DUAL) |
                                          (range_mode == asci_pkg::RANGE_AUTO));
    status_next.zero_cal               = (cal_state_reg == asci_pkg::CAL_ZERO);
    status_next.span_cal               = (cal_state_reg == asci_pkg::CAL_SPAN);
    status_next.diagnostic_active      = diagnostic_active_in;
    status_next.first_threshold_alarm  = alarm_hit[0];
    status_next.second_threshold_alarm = alarm_hit[1];
  end

  // All eight status outputs in one register so the receiver never sees a mixed update
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  assign status_out = status_reg;
  assign mode_out   = mode_reg;

  // Wishbone slave: ack one cycle after the request, then dropped
  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign bus_done = bus_req & ack_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~ack_reg;
  end

  // Read data captured in the request cycle; unmapped offsets read zero
  always_comb
  begin
    rdata_next = 32'h00000000;
    unique case (wb_adr_i)
      asci_pkg::ADR_CTRL:       rdata_next[asci_pkg::CTRL_W-1:0] = ctrl_reg;
      asci_pkg::ADR_SETPOINT1:  rdata_next[CONC_W-1:0] = setpoint_reg[0];
      asci_pkg::ADR_SETPOINT2:  rdata_next[CONC_W-1:0] = setpoint_reg[1];
      asci_pkg::ADR_STATUS:     rdata_next[10:0] = {mode_reg, status_reg};
      asci_pkg::ADR_IRQ_STATUS: rdata_next[asci_pkg::IRQ_W-1:0] = irq_status_reg;
      asci_pkg::ADR_IRQ_MASK:   rdata_next[asci_pkg::IRQ_W-1:0] = irq_mask_reg;
      default:                  rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      rdata_reg <= 32'h00000000;
    else if (bus_req & ~ack_reg)
      rdata_reg <= rdata_next;
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Write word: enabled lanes from the bus, the rest from the addressed register
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wr_word[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : rdata_next[b*8 +: 8];
  end

  // Register writes land on the edge where the master sees ack
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctrl_reg        <= asci_pkg::CTRL_RST;
      setpoint_reg[0] <= asci_pkg::SETPOINT_RST[CONC_W-1:0];
      setpoint_reg[1] <= asci_pkg::SETPOINT_RST[CONC_W-1:0];
      irq_mask_reg    <= asci_pkg::IRQ_RST;
    end
    else if (bus_done & wb_we_i)
    begin
      unique case (wb_adr_i)
        asci_pkg::ADR_CTRL:
          ctrl_reg <= wr_word[asci_pkg::CTRL_W-1:0];
        asci_pkg::ADR_SETPOINT1:
          setpoint_reg[0] <= wr_word[CONC_W-1:0];
        asci_pkg::ADR_SETPOINT2:
          setpoint_reg[1] <= wr_word[CONC_W-1:0];
        asci_pkg::ADR_IRQ_MASK:
          if (wb_sel_i[0])
            irq_mask_reg <= wb_dat_i[asci_pkg::IRQ_W-1:0];
        default:
          ;
      endcase
    end
  end

  // Events: new fault, alarm onset, remote request onset
  always_comb
  begin
    irq_set = '0;
    irq_set[asci_pkg::IRQ_FAULT]       = status_reg.system_ok & ~status_next.system_ok;
    irq_set[asci_pkg::IRQ_FIRST_THRESHOLD_ALARM]      = alarm_hit[0] & ~status_reg.first_threshold_alarm;
    irq_set[asci_pkg::IRQ_SECOND_THRESHOLD_ALARM]      = alarm_hit[1] & ~status_reg.second_threshold_alarm;
    irq_set[asci_pkg::IRQ_REMOTE_ZERO] = zero_sync & ~zero_sync_prev_reg;
    irq_set[asci_pkg::IRQ_REMOTE_SPAN] = span_sync & ~span_sync_prev_reg;
  end

  // A read clears only the bits it returned, so no event is lost; set wins
  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (bus_done & ~wb_we_i & (wb_adr_i == asci_pkg::ADR_IRQ_STATUS))
      irq_status_next = irq_status_reg & ~rdata_reg[asci_pkg::IRQ_W-1:0];
    irq_status_next = irq_status_next | irq_set;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_status_reg <= asci_pkg::IRQ_RST;
    else
      irq_status_reg <= irq_status_next;
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // Checks on the outputs and the input synchroniser, status outputs one cycle behind their causes
  a_healthy_no_fault: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> (status_out.system_ok == !(|$past(fault_flags))))
    else $error("system ok output does not follow fault flags");

  a_valid_follows_reading: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> (status_out.reading_valid_flag == $past(reading_ok)))
    else $error("reading valid output does not follow reading state");

  a_high_range_mode: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    status_out.high_range |-> ($past(upper_range) &&
      ($past(range_mode) inside {asci_pkg::RANGE_DUAL, asci_pkg::RANGE_AUTO})))
    else $error("high range output outside dual or auto upper range");

  a_zero_cal_span: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (cal_state_reg == asci_pkg::CAL_ZERO) [*3] |-> status_out.zero_cal)
    else $error("zero calibration output dropped during zero calibration");

  a_span_cal_span: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> (status_out.span_cal == ($past(cal_state_reg) == asci_pkg::CAL_SPAN)))
    else $error("span calibration output does not match span phase");

  a_diag_follows_mode: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(diagnostic_active_in) |=> status_out.diagnostic_active)
    else $error("diagnostic output late after diagnostic mode");

  a_alarm_threshold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> (status_out.first_threshold_alarm ==
      ($past(concentration) > $past(setpoint_reg[0]))) &&
      (status_out.second_threshold_alarm ==
      ($past(concentration) > $past(setpoint_reg[1]))))
    else $error("alarm output does not match setpoint comparison");

  a_remote_zero_enter: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(zero_sync) |=>
      (cal_state_reg == asci_pkg::CAL_ZERO && mode_out.cal_zero && mode_out.cal_remote)
      ##1 status_out.zero_cal)
    else $error("remote zero request did not enter remote zero calibration");

  a_remote_span_enter: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ($rose(span_sync) && !zero_req && cal_state_reg == asci_pkg::CAL_IDLE) |=>
      (cal_state_reg == asci_pkg::CAL_SPAN && mode_out.cal_span && mode_out.cal_remote))
    else $error("remote span request did not enter remote span calibration");

  a_sync_two_stage: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ($past(rstn) && $past(rstn, 2)) |-> (zero_sync == $past(remote_zero_in, 2)) &&
      (span_sync == $past(remote_span_in, 2)))
    else $error("control input not delayed by exactly two stages");

  a_reset_clears_out: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(rstn) |-> (status_out == '0 && mode_out == '0 && !irq_o))
    else $error("outputs not inactive right after reset");

endmodule : asci_status_io

// ===== verification/asci_plc_model.sv
`timescale 1ns/100ps

// Logic controller on the far side, driving the remote calibration lines
module asci_plc_model (
  input  wire logic sys_clk,
  input  wire logic zero_cmd,
  input  wire logic span_cmd,
  output logic      remote_zero_in,
  output logic      remote_span_in
);

  // Lines start inactive so the device sees no request before the first edge
  initial
  begin
    remote_zero_in = 1'b0;
    remote_span_in = 1'b0;
  end

  // Output stage re-times commands, so lines change only on the rising edge
  always @(posedge sys_clk)
  begin
    remote_zero_in <= zero_cmd;
    remote_span_in <= span_cmd;
  end

endmodule : asci_plc_model

// ===== verification/asci_status_io_bench.sv
`timescale 1ns/100ps

module asci_status_io_bench;

  logic                      sys_clk        = 1'b0;
  logic                      rstn           = 1'b0;
  logic                      wb_cyc_i       = 1'b0;
  logic                      wb_stb_i       = 1'b0;
  logic                      wb_we_i        = 1'b0;
  logic [7:0]                wb_adr_i       = 8'h00;
  logic [3:0]                wb_sel_i       = 4'h0;
  logic [31:0]               wb_dat_i       = 32'h00000000;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  logic                      irq_o;
  logic [7:0]                fault_flags    = 8'h00;
  logic                      reading_ok     = 1'b0;
  logic                      upper_range    = 1'b0;
  logic                      diagnostic_active_in   = 1'b0;
  logic [15:0]               concentration  = 16'h0000;
  logic                      remote_zero_in;
  logic                      remote_span_in;
  logic [3:0]                spare_in       = 4'h0;
  asci_pkg::asci_status_type status_out;
  asci_pkg::asci_mode_type   mode_out;
  logic                      zero_cmd       = 1'b0;
  logic                      span_cmd       = 1'b0;
  logic [3:0]                ctrl_v         = 4'h0;
  logic [15:0]               sp1_v          = 16'h0000;
  logic [15:0]               sp2_v          = 16'h0000;
  logic [31:0]               rd_v;
  logic [10:0]               e;
  int                        miscompares    = 0;
  int                        total_checks   = 0;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  asci_status_io dut (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .fault_flags(fault_flags),
    .reading_ok(reading_ok), .upper_range(upper_range), .diagnostic_active_in(diagnostic_active_in),
    .concentration(concentration), .remote_zero_in(remote_zero_in),
    .remote_span_in(remote_span_in), .spare_in(spare_in), .status_out(status_out),
    .mode_out(mode_out)
  );

  asci_plc_model plc (
    .sys_clk(sys_clk), .zero_cmd(zero_cmd), .span_cmd(span_cmd),
    .remote_zero_in(remote_zero_in), .remote_span_in(remote_span_in)
  );

  // Mode and status the outputs should settle to, zero calibration winning over span
  function automatic logic [10:0] exp_out;
    logic                      zr;
    logic                      sr;
    asci_pkg::asci_status_type s;
    asci_pkg::asci_mode_type   m;
    zr = ctrl_v[0] | zero_cmd;
    sr = ctrl_v[1] | span_cmd;
    s.system_ok = ~|fault_flags;
    s.reading_valid_flag = reading_ok;
    s.high_range = upper_range & (ctrl_v[3:2] == 2'h1 || ctrl_v[3:2] == 2'h2);
    s.zero_cal = zr;
    s.span_cal = sr & ~zr;
    s.diagnostic_active = diagnostic_active_in;
    s.first_threshold_alarm = concentration > sp1_v;
    s.second_threshold_alarm = concentration > sp2_v;
    m.cal_zero = zr;
    m.cal_span = sr & ~zr;
    m.cal_remote = zr ? zero_cmd : (sr & span_cmd);
    return {m, s};
  endfunction : exp_out

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    total_checks++;
    if (seen !== expected)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  // One classic cycle; held until ack is sampled high, then released for a cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    rd_v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Watchdog, well beyond the few thousand cycles the tests need
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(77));
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    check(32'(status_out), 32'h0);
    check(32'({mode_out, irq_o}), 32'h0);
    wb_cycle(1'b0, asci_pkg::ADR_CTRL, 32'h0, 4'hF);
    check(rd_v, 32'h0);
    wb_cycle(1'b0, asci_pkg::ADR_SETPOINT1, 32'h0, 4'hF);
    check(32'(rd_v[15:0]), 32'h0000FFFF);
    wb_cycle(1'b0, 8'h1C, 32'h0, 4'hF);
    check(rd_v, 32'h0);
    // Random operating points, concentration kept within one count of the first setpoint
    for (int i = 0; i < 120; i++)
    begin
      ctrl_v = 4'($urandom);
      sp1_v = 16'($urandom_range(255, 1));
      sp2_v = 16'($urandom_range(511, 0));
      wb_cycle(1'b1, asci_pkg::ADR_CTRL, 32'(ctrl_v), 4'hF);
      wb_cycle(1'b1, asci_pkg::ADR_SETPOINT1, 32'(sp1_v), 4'hF);
      wb_cycle(1'b1, asci_pkg::ADR_SETPOINT2, 32'(sp2_v), 4'hF);
      wb_cycle(1'b1, asci_pkg::ADR_STATUS, 32'hFFFFFFFF, 4'hF);
      @(posedge sys_clk);
      fault_flags <= ($urandom_range(3, 0) == 0) ? 8'($urandom) : 8'h00;
      reading_ok <= 1'($urandom);
      upper_range <= 1'($urandom);
      diagnostic_active_in <= 1'($urandom);
      spare_in <= 4'($urandom);
      concentration <= sp1_v + 16'($urandom_range(2, 0)) - 16'h0001;
      zero_cmd <= 1'($urandom);
      span_cmd <= 1'($urandom);
      repeat (7) @(posedge sys_clk);
      e = exp_out();
      check(32'(status_out.system_ok), 32'(e[0]));
      check(32'(status_out.reading_valid_flag), 32'(e[1]));
      check(32'(status_out.high_range), 32'(e[2]));
      check(32'(status_out.zero_cal), 32'(e[3]));
      check(32'(status_out.span_cal), 32'(e[4]));
      check(32'(status_out.diagnostic_active), 32'(e[5]));
      check(32'(status_out.first_threshold_alarm), 32'(e[6]));
      check(32'(status_out.second_threshold_alarm), 32'(e[7]));
      check(32'(mode_out), 32'(e[10:8]));
      wb_cycle(1'b0, asci_pkg::ADR_STATUS, 32'h0, 4'hF);
      check(32'(rd_v[10:0]), 32'(e));
    end
    // Reset in mid-run clears every output at once
    @(posedge sys_clk);
    rstn <= 1'b0;
    zero_cmd <= 1'b0;
    span_cmd <= 1'b0;
    fault_flags <= 8'h00;
    concentration <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    check(32'({mode_out, status_out}), 32'h0);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // Interrupt masked, then unmasked, then cleared by reading
    wb_cycle(1'b0, asci_pkg::ADR_IRQ_STATUS, 32'h0, 4'hF);
    @(posedge sys_clk);
    fault_flags <= 8'h04;
    repeat (5) @(posedge sys_clk);
    check(32'(irq_o), 32'h0);
    wb_cycle(1'b1, asci_pkg::ADR_IRQ_MASK, 32'h1F, 4'h1);
    repeat (2) @(posedge sys_clk);
    check(32'(irq_o), 32'h1);
    wb_cycle(1'b0, asci_pkg::ADR_IRQ_STATUS, 32'h0, 4'hF);
    check(32'(rd_v[4:0]), 32'h01);
    repeat (2) @(posedge sys_clk);
    check(32'(irq_o), 32'h0);
    // Write without byte enable leaves the mask alone
    wb_cycle(1'b1, asci_pkg::ADR_IRQ_MASK, 32'h0, 4'h0);
    span_cmd <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(32'(irq_o), 32'h1);
    check(32'(mode_out), 32'h6);
    wb_cycle(1'b0, asci_pkg::ADR_IRQ_STATUS, 32'h0, 4'hF);
    check(32'(rd_v[4:0]), 32'h10);
    zero_cmd <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(32'({mode_out, status_out.zero_cal, status_out.span_cal}), 32'h16);
    wb_cycle(1'b0, asci_pkg::ADR_IRQ_STATUS, 32'h0, 4'hF);
    check(32'(rd_v[4:0]), 32'h08);
    give_verdict();
  end

endmodule : asci_status_io_bench
